// ==== design/oscm_pkg.sv ====
// Package for the oscillator selection and fail-safe monitor block.
// Assumes a single 10 MHz system clock and an Avalon-MM register slave.
`default_nettype none
package oscm_pkg;
  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY     = 4'h4;
  localparam logic [3:0] ADDR_STAT    = 4'h8;
  // ---------------------------------------------------------------------
  // Field positions within oscillator_control
  // ---------------------------------------------------------------------
  localparam int BIT_SWREQ  = 0;
  localparam int BIT_LPOSC  = 1;
  localparam int BIT_CFAIL  = 3;
  localparam int BIT_LOCK   = 5;
  localparam int POS_NEWG   = 8;
  localparam int POS_TRIMLO = 10;
  localparam int POS_CURG   = 12;
  localparam int POS_TRIMHI = 14;
  // ---------------------------------------------------------------------
  // Unlock keys
  // ---------------------------------------------------------------------
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9a;
  // ---------------------------------------------------------------------
  // Groups and timing
  // ---------------------------------------------------------------------
  localparam logic [1:0] GRP_SEC  = 2'h0;
  localparam logic [1:0] GRP_FRC  = 2'h1;
  localparam logic [1:0] GRP_SLOW_RC_OSC = 2'h2;
  localparam logic [1:0] GRP_PRI  = 2'h3;
  localparam int         OST_CYCLES   = 1024;
  localparam logic [9:0] OST_LAST     = 10'h3ff;
  localparam int         STARTUP_WAIT = 1100;
  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_START = 2'b01,
    SW_CHANGE= 2'b11
  } oscm_sw_t;
  typedef struct packed {
    logic       sleep;
    logic       por;
    logic       bor;
    logic       wdt_en;
    logic       osc_fail;
  } oscm_evt_t;
endpackage : oscm_pkg
`default_nettype wire

// ==== design/oscm_ctrl.sv ====
// Oscillator group control, start-up timer, trim and fail-safe monitor.
// Assumes every input synchronous to ref_clk_i; oscillators are external.
// Notes on behaviour
// (RULE_01) A 10-bit start-up counter counts 1024 ticks before releasing the clock.
// (RULE_02) The start-up delay applies on power-on, brown-out and Sleep wake.
// (RULE_03) The 32 kHz oscillator runs whenever its enable is set, Sleep too.
// (RULE_04) The 32 kHz oscillator clocks the device only in group 00 with enable.
// (RULE_05) The PLL multiplies the primary clock by four, eight or sixteen.
// (RULE_06) Lock indication follows the PLL and is mirrored read-only.
// (RULE_07) The device runs from fast RC when current group is 01.
// (RULE_08) The 4-bit trim at bits 15:14,11:10 steps fast RC in 1.5%.
// (RULE_09) The slow RC clocks power-up timer, watchdog and clock monitor.
// (RULE_10) Slow RC on at power-on; afterwards only if monitor, watchdog or selected.
// (RULE_11) With the monitor enabled slow RC runs except in Sleep.
// (RULE_12) Oscillator failure raises a trap and falls back to fast RC.
// (RULE_13) On failure load fast RC group, set fail flag, clear switch request.
// (RULE_14) A clock failure leaves the watchdog running on slow RC; wdt_en is ignored with the monitor on, so slow RC stops in Sleep.
// (RULE_15) A start-up that outlasts the power-up timer is treated as failure.
// (RULE_16) Switching moves between four groups; primary choice comes from config.
// (RULE_17) Current group shows the group in effect; new group is writable.
// (RULE_18) Power-on and brown-out load both groups from the group config.
// (RULE_19) Switch request rises at start; clearing it aborts a transition.
// (RULE_20) Monitor config 1x disables both switching and the monitor.
// (RULE_21) With switching disabled the config selects; current group only mirrors.
// (RULE_22) Software should not switch below 100 kHz with the monitor on.
// (RULE_23) Group config codes: 00 secondary, 01 fast RC, 10 slow RC, 11 primary.
// (RULE_24) Each register byte is writable only right after its two-byte key.
// (RULE_25) A switch starts the new source, changes over, updates, then clears.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module oscm_ctrl
  import oscm_pkg::*;
#(
  parameter int STARTUP_LIMIT = STARTUP_WAIT
)(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Configuration and system events
  input  wire logic [1:0]  group_config_i,
  input  wire logic [3:0]  primary_config_i,
  input  wire logic [1:0]  monitor_config_i,
  input  wire oscm_evt_t   evt_i,
  input  wire logic        powerup_timer_expired_i,
  input  wire logic        osc_tick_i,
  input  wire logic        pll_locked_i,
  // Oscillator controls
  output logic             sec_osc_on_o,
  output logic             slow_rc_on_o,
  output logic             clk_release_o,
  output logic [1:0]       clk_select_o,
  output logic [3:0]       primary_sel_o,
  output logic [4:0]       pll_gain_o,
  output logic [3:0]       fast_rc_trim_o,
  output logic             pll_lock_o,
  output logic             clk_fail_trap_o
);
  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [1:0]  cur_grp_ff, new_grp_ff;
  logic        swreq_ff, lposc_ff, cfail_ff, lock_ff;
  logic [3:0]  trim_ff;
  logic [9:0]  ost_cnt_ff;
  logic        ost_run_ff, ost_done_ff;
  logic [10:0] wait_cnt_ff;
  logic        lo_key1_ff, lo_open_ff, hi_key1_ff, hi_open_ff;
  logic        ack_ff, wait_ff;
  logic [31:0] rdata_ff;
  oscm_sw_t    sw_ff;
  logic        slow_on_ff, sec_on_ff, rel_ff, trap_ff;
  logic [1:0]  sel_ff;
  logic [4:0]  gain_ff;
  logic [3:0]  psel_ff;
  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  wire sw_enabled  = ~monitor_config_i[1];                   // RULE_20
  wire mon_enabled = ~monitor_config_i[1];                   // RULE_20
  // A transfer completes at the edge where waitrequest is seen low.
  wire acc         = (avs_read_i | avs_write_i) & ~ack_ff;
  wire done        = (avs_read_i | avs_write_i) & ack_ff;
  wire wr          = avs_write_i & ack_ff;
  wire hit_ctrl    = avs_address_i == ADDR_OSC_CTRL;
  wire hit_key     = avs_address_i == ADDR_KEY;
  wire wr_key_lo   = wr & hit_key & avs_byteenable_i[0];
  wire wr_key_hi   = wr & hit_key & avs_byteenable_i[1];
  wire wr_lo       = wr & hit_ctrl & avs_byteenable_i[0] & lo_open_ff; // RULE_24
  wire wr_hi       = wr & hit_ctrl & avs_byteenable_i[1] & hi_open_ff; // RULE_24
  wire [7:0] kd_lo = avs_writedata_i[7:0];
  wire [7:0] kd_hi = avs_writedata_i[15:8];
  wire restart     = evt_i.por | evt_i.bor;
  wire osc_restart = restart | evt_i.sleep;
  // Crystal modes: secondary group, or primary crystal codes 0xxx.
  wire xtal_mode   = (cur_grp_ff == GRP_SEC) |
                     ((cur_grp_ff == GRP_PRI) & ~primary_config_i[3]); // RULE_02
  wire ost_expired = ost_run_ff & osc_tick_i & (ost_cnt_ff == OST_LAST);
  wire slow_start  = mon_enabled & ost_run_ff & powerup_timer_expired_i &
                     (wait_cnt_ff == 11'(STARTUP_LIMIT));     // RULE_15
  wire fail_now    = mon_enabled & (evt_i.osc_fail | slow_start); // RULE_12
  wire sw_start    = sw_enabled & swreq_ff & (new_grp_ff != cur_grp_ff);
  wire new_ready   = (new_grp_ff == GRP_FRC) | (new_grp_ff == GRP_SLOW_RC_OSC) |
                     ost_done_ff;                           // RULE_23
  wire sw_ctrl_clr = wr_lo & ~avs_writedata_i[BIT_SWREQ];
  wire [15:0] ctrl_word = {trim_ff[3:2], cur_grp_ff, trim_ff[1:0],
                           new_grp_ff, 2'h0, lock_ff, 1'b0, cfail_ff,
                           1'b0, lposc_ff, swreq_ff};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0, ctrl_word} :
                       (avs_address_i == ADDR_STAT) ?
                       {24'h0, 1'b0, sw_ff, ost_done_ff, 2'h0,
                        cur_grp_ff} : 32'h0;
  // -----------------------------------------------------------------------
  // Bus slave: one wait state, unmapped reads return zero.
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end
    else
    begin
      ack_ff   <= acc;
      wait_ff  <= ~acc;
      rdata_ff <= rd_mux;
    end
  end
  // Key sequence: a key opens the byte for the next bus access only.
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      lo_key1_ff <= 1'b0;
      lo_open_ff <= 1'b0;
      hi_key1_ff <= 1'b0;
      hi_open_ff <= 1'b0;
    end
    else if (done)
    begin
      lo_key1_ff <= wr_key_lo & (kd_lo == KEY_LO_A);          // RULE_24
      lo_open_ff <= wr_key_lo & (kd_lo == KEY_LO_B) & lo_key1_ff;
      hi_key1_ff <= wr_key_hi & (kd_hi == KEY_HI_A);          // RULE_24
      hi_open_ff <= wr_key_hi & (kd_hi == KEY_HI_B) & hi_key1_ff;
    end
  end
  // -----------------------------------------------------------------------
  // Oscillator start-up timer
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ost_cnt_ff  <= 10'h0;
      ost_run_ff  <= 1'b0;
      ost_done_ff <= 1'b0;
      wait_cnt_ff <= 11'h0;
    end
    else if ((osc_restart & xtal_mode) | (sw_ff == SW_START & ~ost_run_ff &
             ~ost_done_ff & ~new_ready))
    begin
      ost_cnt_ff  <= 10'h0;                                   // RULE_02
      ost_run_ff  <= 1'b1;
      ost_done_ff <= 1'b0;
      wait_cnt_ff <= 11'h0;
    end
    else if (fail_now)
    begin
      ost_run_ff  <= 1'b0;
      ost_done_ff <= 1'b0;
    end
    else if (ost_run_ff)
    begin
      if (osc_tick_i)
        ost_cnt_ff <= ost_cnt_ff + 10'h1;                     // RULE_01
      if (ost_expired)
      begin
        ost_run_ff  <= 1'b0;
        ost_done_ff <= 1'b1;                                  // RULE_01
      end
      if (powerup_timer_expired_i && wait_cnt_ff != 11'(STARTUP_LIMIT))
        wait_cnt_ff <= wait_cnt_ff + 11'h1;
    end
    else if (sw_ff == SW_IDLE && !osc_restart)
      ost_done_ff <= ost_done_ff & ~sw_start;
  end
  // -----------------------------------------------------------------------
  // Clock switch sequencer and oscillator_control fields
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      cur_grp_ff <= GRP_FRC;
      new_grp_ff <= GRP_FRC;
      swreq_ff   <= 1'b0;
      lposc_ff   <= 1'b0;
      cfail_ff   <= 1'b0;
      trim_ff    <= 4'h0;
      sw_ff      <= SW_IDLE;
    end
    else if (restart)
    begin
      cur_grp_ff <= group_config_i;                           // RULE_18
      new_grp_ff <= group_config_i;                           // RULE_18
      swreq_ff   <= 1'b0;
      sw_ff      <= SW_IDLE;
    end
    else if (fail_now)
    begin
      cur_grp_ff <= GRP_FRC;                                  // RULE_13
      cfail_ff   <= 1'b1;                                     // RULE_13
      swreq_ff   <= 1'b0;                                     // RULE_13
      sw_ff      <= SW_IDLE;
    end
    else
    begin
      if (wr_lo)
      begin
        swreq_ff   <= avs_writedata_i[BIT_SWREQ];             // RULE_19
        lposc_ff   <= avs_writedata_i[BIT_LPOSC];
      end
      if (wr_hi)
      begin
        new_grp_ff <= avs_writedata_i[POS_NEWG +: 2];         // RULE_17
        trim_ff    <= {avs_writedata_i[POS_TRIMHI +: 2],
                       avs_writedata_i[POS_TRIMLO +: 2]};     // RULE_08
      end
      if (!sw_enabled)
        cur_grp_ff <= group_config_i;                         // RULE_21
      case (sw_ff)
        SW_IDLE:
          if (sw_start)
            sw_ff <= SW_START;                                // RULE_25
        SW_START:
          if (sw_ctrl_clr || !sw_enabled)
            sw_ff <= SW_IDLE;                                 // RULE_19
          else if (new_ready)
            sw_ff <= SW_CHANGE;
        SW_CHANGE:
        begin
          sw_ff <= SW_IDLE;
          if (!sw_ctrl_clr)
          begin
            cur_grp_ff <= new_grp_ff;                         // RULE_16
            swreq_ff   <= 1'b0;                               // RULE_25
          end
        end
        default:
          sw_ff <= SW_IDLE;
      endcase
    end
  end
  // -----------------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      lock_ff    <= 1'b0;
      slow_on_ff <= 1'b1;
      sec_on_ff  <= 1'b0;
      rel_ff     <= 1'b0;
      trap_ff    <= 1'b0;
      sel_ff     <= GRP_FRC;
      gain_ff    <= 5'h1;
      psel_ff    <= 4'h0;
    end
    else
    begin
      lock_ff    <= pll_locked_i;                             // RULE_06
      // Watchdog and monitor need slow RC; wdt_en keeps it on only while the monitor is disabled.
      slow_on_ff <= evt_i.por | ~powerup_timer_expired_i |             // RULE_10
                    (mon_enabled & ~evt_i.sleep) |            // RULE_11
                    (~mon_enabled & evt_i.wdt_en) |           // RULE_14
                    (cur_grp_ff == GRP_SLOW_RC_OSC);                 // RULE_09
      sec_on_ff  <= lposc_ff;                                 // RULE_03
      rel_ff     <= ~ost_run_ff & ((cur_grp_ff != GRP_SEC) | lposc_ff)
                    & ((gain_ff == 5'h1) | pll_locked_i);     // RULE_04
      trap_ff    <= fail_now;                                 // RULE_12
      sel_ff     <= cur_grp_ff;                               // RULE_07
      psel_ff    <= primary_config_i;                         // RULE_16
      case (primary_config_i[1:0])                            // RULE_05
        2'h1:    gain_ff <= primary_config_i[2] ? 5'h4 : 5'h1;
        2'h2:    gain_ff <= primary_config_i[2] ? 5'h8 : 5'h1;
        2'h3:    gain_ff <= primary_config_i[2] ? 5'h10 : 5'h1;
        default: gain_ff <= 5'h1;
      endcase
    end
  end
  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign sec_osc_on_o      = sec_on_ff;
  assign slow_rc_on_o      = slow_on_ff;
  assign clk_release_o     = rel_ff;
  assign clk_select_o      = sel_ff;
  assign primary_sel_o     = psel_ff;
  assign pll_gain_o        = gain_ff;
  assign fast_rc_trim_o    = trim_ff;
  assign pll_lock_o        = lock_ff;
  assign clk_fail_trap_o   = trap_ff;
  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  AST_FAIL_FALLBACK: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_13
    fail_now && !restart |=> cur_grp_ff == GRP_FRC && cfail_ff && !swreq_ff)
    else $error("failure did not fall back to fast RC");
  AST_FAIL_TRAP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_12
    fail_now |=> clk_fail_trap_o)
    else $error("trap not raised on failure");
  AST_LOCK_MIRROR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_06
    pll_locked_i |=> pll_lock_o && ctrl_word[BIT_LOCK])
    else $error("lock not mirrored");
  AST_OST_LEN: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_01
    ost_expired && !fail_now && !osc_restart |=> ost_done_ff && !ost_run_ff)
    else $error("start-up timer did not finish");
  AST_RESET_LOAD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_18
    restart |=> cur_grp_ff == $past(group_config_i) && new_grp_ff == cur_grp_ff)
    else $error("groups not loaded from config");
  AST_NO_SWITCH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_20
    monitor_config_i[1] |-> ##1 (sw_ff == SW_IDLE || $past(sw_ff) != SW_IDLE))
    else $error("switch started while disabled");
  AST_SEC_ON: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_03
    lposc_ff |=> sec_osc_on_o)
    else $error("32 kHz oscillator off while enabled");
  AST_SLOW_MON: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_11
    mon_enabled && !evt_i.sleep |=> slow_rc_on_o)
    else $error("slow RC off while monitor enabled");
endmodule : oscm_ctrl
`default_nettype wire

// ==== bench/oscm_xtal_model.sv ====
// Behavioural crystal oscillator and PLL on the far side of the block.
// Assumes the bench clock; one tick stands for one oscillator period.
`default_nettype none
module oscm_xtal_model #(
  parameter int TICK_DIV   = 2,
  parameter int LOCK_DELAY = 8
)(
  // Clock
  input  wire logic ref_clk_i,
  // Controls from the bench
  input  wire logic run_i,
  input  wire logic lock_req_i,
  // Oscillator and PLL outputs
  output logic      osc_tick_o,
  output logic      pll_locked_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int div_cnt  = 0;
  int lock_cnt = 0;
  initial
  begin
    osc_tick_o   = 1'b0;
    pll_locked_o = 1'b0;
  end
  // A stopped crystal gives no ticks; lock is lost at once on request drop.
  always @(posedge ref_clk_i)
  begin
    div_cnt      <= run_i ? (div_cnt + 1) % TICK_DIV : 0;
    osc_tick_o   <= run_i && (div_cnt == TICK_DIV - 1);
    lock_cnt     <= lock_req_i ? lock_cnt + (lock_cnt < LOCK_DELAY) : 0;
    pll_locked_o <= lock_req_i && (lock_cnt == LOCK_DELAY);
  end
endmodule : oscm_xtal_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the oscillator control block.
// Assumes the crystal model beside it and an Avalon-MM master in tasks.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import oscm_pkg::*;
  logic        ref_clk_i = 1'b0, resetn_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic        avs_waitrequest_o, powerup_timer_exp = 1'b0, lock_req = 1'b0;
  logic [1:0]  grp_cfg = GRP_FRC, mon_cfg = 2'h0, clk_select_o;
  logic [3:0]  pri_cfg = 4'h4, primary_sel_o, fast_rc_trim_o;
  logic [4:0]  pll_gain_o;
  oscm_evt_t   evt = '0;
  logic        tick, locked, sec_osc_on_o, slow_rc_on_o, clk_release_o;
  logic        pll_lock_o, clk_fail_trap_o, seen;
  int          err_total = 0, total_checks = 0;
  logic [3:0]  trims [4] = '{4'h7, 4'h8, 4'hf, 4'h0};
  logic [3:0]  pcfg  [4] = '{4'h5, 4'h6, 4'h7, 4'hf};
  logic [4:0]  gains [4] = '{5'h04, 5'h08, 5'h10, 5'h10};
  always #50 ref_clk_i = ~ref_clk_i;
  oscm_xtal_model oscm_xtal_model_i (.ref_clk_i(ref_clk_i), .run_i(1'b1),
    .lock_req_i(lock_req), .osc_tick_o(tick), .pll_locked_o(locked));
  oscm_ctrl #(.STARTUP_LIMIT(20)) oscm_ctrl_i (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .group_config_i(grp_cfg), .primary_config_i(pri_cfg),
    .monitor_config_i(mon_cfg), .evt_i(evt), .powerup_timer_expired_i(powerup_timer_exp),
    .osc_tick_i(tick), .pll_locked_i(locked), .sec_osc_on_o(sec_osc_on_o),
    .slow_rc_on_o(slow_rc_on_o), .clk_release_o(clk_release_o),
    .clk_select_o(clk_select_o), .primary_sel_o(primary_sel_o),
    .pll_gain_o(pll_gain_o), .fast_rc_trim_o(fast_rc_trim_o),
    .pll_lock_o(pll_lock_o), .clk_fail_trap_o(clk_fail_trap_o));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic results();
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i    <= a;
    avs_write_i      <= w;
    avs_read_i       <= !w;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    if (n >= 50)
      check(32'h0, 32'h1);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus
  // Each control byte write is preceded directly by its own key pair.
  task automatic ctrl_hi(input logic [7:0] v);
    bus(1'b1, ADDR_KEY, {16'h0, KEY_HI_A, 8'h0}, 4'h2);
    bus(1'b1, ADDR_KEY, {16'h0, KEY_HI_B, 8'h0}, 4'h2);
    bus(1'b1, ADDR_OSC_CTRL, {16'h0, v, 8'h0}, 4'h2);
  endtask : ctrl_hi
  task automatic ctrl_lo(input logic [7:0] v);
    bus(1'b1, ADDR_KEY, {24'h0, KEY_LO_A}, 4'h1);
    bus(1'b1, ADDR_KEY, {24'h0, KEY_LO_B}, 4'h1);
    bus(1'b1, ADDR_OSC_CTRL, {24'h0, v}, 4'h1);
  endtask : ctrl_lo
  task automatic poll_grp(input logic [1:0] g, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
      if (q[13:12] === g && q[0] === 1'b0)
        break;
    end
  endtask : poll_grp
  task automatic pulse_fail();
    int i;
    evt.osc_fail <= 1'b1;
    @(posedge ref_clk_i);
    evt.osc_fail <= 1'b0;
    seen = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge ref_clk_i);
      seen = seen | (clk_fail_trap_o === 1'b1);
    end
  endtask : pulse_fail
  task automatic pulse_por();
    evt.por <= 1'b1;
    @(posedge ref_clk_i);
    evt.por <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : pulse_por
  // ---------------------------------------------------------------------
  // Watchdog and test sequence
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
    check(q, 32'h0000_1100);
    check(slow_rc_on_o, 1'b1);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    check(q, 32'h0);
    // A write without its key must leave the trim untouched.
    bus(1'b1, ADDR_OSC_CTRL, 32'h0000_c500, 4'h2);
    check(fast_rc_trim_o, 4'h0);
    foreach (trims[i])
    begin
      ctrl_hi({trims[i][3:2], 2'b00, trims[i][1:0], GRP_FRC});
      bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
      check({q[15:14], q[11:10]}, trims[i]);
      check(fast_rc_trim_o, trims[i]);
    end
    foreach (pcfg[i])
    begin
      pri_cfg <= pcfg[i];
      repeat (3) @(posedge ref_clk_i);
      check(pll_gain_o, gains[i]);
      check(primary_sel_o, pcfg[i]);
    end
    ctrl_lo(8'h02);
    repeat (2) @(posedge ref_clk_i);
    check(sec_osc_on_o, 1'b1);
    // The crystal model never reports a failure, so a slow target is safe.
    ctrl_hi({6'h0, GRP_SLOW_RC_OSC});
    ctrl_lo(8'h03);
    poll_grp(GRP_SLOW_RC_OSC, 40);
    check(q[13:12], GRP_SLOW_RC_OSC);
    check(clk_select_o, GRP_SLOW_RC_OSC);
    ctrl_hi({6'h0, GRP_SEC});
    ctrl_lo(8'h03);
    poll_grp(GRP_SEC, 1500);
    check({q[13:12], q[0]}, {GRP_SEC, 1'b0});
    check(clk_select_o, GRP_SEC);
    // Withdrawing the request mid-start must leave the old group in force.
    ctrl_hi({6'h0, GRP_PRI});
    ctrl_lo(8'h03);
    ctrl_lo(8'h02);
    repeat (200) @(posedge ref_clk_i);
    bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
    check({q[13:12], q[0]}, {GRP_SEC, 1'b0});
    ctrl_lo(8'h03);
    pulse_fail();
    check(seen, 1'b1);
    bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
    check({q[13:12], q[3], q[0]}, {GRP_FRC, 2'b10});
    check(clk_select_o, GRP_FRC);
    lock_req <= 1'b1;
    repeat (14) @(posedge ref_clk_i);
    check(pll_lock_o, 1'b1);
    bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
    check(q[5], 1'b1);
    lock_req <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    check(pll_lock_o, 1'b0);
    mon_cfg <= 2'h2;
    grp_cfg <= GRP_SLOW_RC_OSC;
    pulse_por();
    bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
    check({q[13:12], q[9:8]}, {GRP_SLOW_RC_OSC, GRP_SLOW_RC_OSC});
    check(clk_select_o, GRP_SLOW_RC_OSC);
    pulse_fail();
    check(seen, 1'b0);
    check(clk_select_o, GRP_SLOW_RC_OSC);
    grp_cfg <= GRP_FRC;
    powerup_timer_exp <= 1'b1;
    pulse_por();
    check(slow_rc_on_o, 1'b0);
    evt.wdt_en <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check(slow_rc_on_o, 1'b1);
    results();
  end
endmodule : tb_top
`default_nettype wire
